// File: adhp_host_port.sv
// Host port of a monochrome character display: registers, windowed
// display memory, font memory, refresh scanner, cursor, pen, keyboard.
// Assumes bus inputs synchronous to i_sys_clk, strobes held to reply.
`timescale 1ns/1ps
module adhp_host_port
    import adhp_pkg::*;
#(
    parameter int CHAR_DIV = 8,
    parameter int BLINK_SLOW = BLINK_SLOW_CYC,
    parameter int BLINK_FAST = BLINK_FAST_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire adhp_req_t i_bus,
    output logic [15:0] o_bus_rdata,
    output logic o_bus_reply,
    input wire logic [9:0] i_csr_base,
    input wire logic [9:0] i_win_base,
    input wire logic [5:0] i_full_base,
    input wire adhp_attr_t i_attr_a,
    input wire adhp_attr_t i_attr_b,
    input wire logic i_small_set,
    input wire logic i_gen_split,
    input wire logic [7:0] i_key_data,
    input wire logic i_key_strobe,
    input wire logic i_lpen_enable,
    input wire logic i_lpen_strobe,
    output adhp_vid_t o_vid,
    output logic o_frame_start
);
    // ************************************************
    // Storage and state
    // ************************************************
    logic [7:0] dm_lo [0:2047];
    logic [7:0] dm_hi [0:2047];
    logic [7:0] cg_lo [0:2047];
    logic [7:0] cg_hi [0:2047];
    logic [7:0] tc_reg [0:15];
    logic [3:0] tc_idx_reg;
    logic [3:0] win_sel_reg;
    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] status_reg;
    logic [7:0] key_code_reg;
    logic key_ready_reg;
    adhp_state_t state_reg;
    logic [7:0] wait_cnt_reg;
    logic done_reg;
    logic is_cg_reg;
    logic [11:0] acc_addr_reg;
    adhp_req_t req_reg;
    logic key_d_reg;
    logic lpen_d_reg;

    // Attribute strap to flag vector {fg_off, blink, tall, underline, inverse}
    function automatic logic [4:0] attr_flags(input adhp_attr_t sel);
        logic [4:0] f;
        f = 5'h00;
        case (sel)
            ATTR_INVERSE: f = 5'h01;
            ATTR_UNDERLINE: f = 5'h02;
            ATTR_TALL: f = 5'h04;
            ATTR_BLINK: f = 5'h08;
            ATTR_FG_OFF: f = 5'h10;
            default: f = 5'h00;
        endcase
        return f;
    endfunction

    // ************************************************
    // Address decode
    // ************************************************
    logic io_hit, win_hit, full_hit, mem_hit, take, ref_busy;
    logic lo_lane, hi_lane, key_pulse, lpen_pulse, key_rd;
    logic [1:0] ofs;
    assign io_hit = (i_bus.addr[17:13] == IO_PAGE) && (i_bus.addr[12:3] == i_csr_base);
    assign win_hit = ctrl1_reg[C1_WIN_EN] && (i_bus.addr[17:8] == i_win_base);
    assign full_hit = ctrl1_reg[C1_FULL_EN] && (i_bus.addr[17:12] == i_full_base);
    assign mem_hit = !io_hit && (win_hit || full_hit);
    assign take = (state_reg == ST_IDLE) && (i_bus.rd || i_bus.wr) && (io_hit || mem_hit);
    assign ofs = i_bus.addr[2:1];
    // Byte lanes of a write
    assign lo_lane = !i_bus.byte_wr || !i_bus.addr[0];
    assign hi_lane = !i_bus.byte_wr || i_bus.addr[0];
    assign key_pulse = i_key_strobe && !key_d_reg;
    assign lpen_pulse = i_lpen_strobe && !lpen_d_reg && i_lpen_enable;
    assign key_rd = take && io_hit && i_bus.rd && (ofs == OFS_4);

    // ************************************************
    // Bus cycle engine and host memory access
    // ************************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            wait_cnt_reg <= 8'h00;
            done_reg <= 1'b0;
            is_cg_reg <= 1'b0;
            acc_addr_reg <= 12'h000;
            req_reg <= '0;
            o_bus_rdata <= 16'h0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (take && io_hit) begin
                        state_reg <= ST_DONE;
                        case (ofs)
                            OFS_0: o_bus_rdata <= {8'h00, status_reg};
                            OFS_2: o_bus_rdata <= {8'h00, tc_reg[tc_idx_reg]};
                            OFS_4: o_bus_rdata <= {8'h00, key_code_reg};
                            default: o_bus_rdata <= {8'h00, key_ready_reg, 7'h00};
                        endcase
                    end else if (take) begin
                        state_reg <= ST_WAIT;
                        wait_cnt_reg <= 8'h00;
                        done_reg <= 1'b0;
                        req_reg <= i_bus;
                        is_cg_reg <= !full_hit && ctrl1_reg[C1_CG_EN];
                        // Full map wins over the window
                        acc_addr_reg <= full_hit ? i_bus.addr[11:0]
                            : {win_sel_reg, i_bus.addr[7:0]};
                    end
                end
                ST_WAIT: begin
                    wait_cnt_reg <= wait_cnt_reg + 8'h01;
                    if (!done_reg && !ref_busy) begin
                        done_reg <= 1'b1;
                        o_bus_rdata <= is_cg_reg
                            ? {cg_hi[acc_addr_reg[11:1]], cg_lo[acc_addr_reg[11:1]]}
                            : {dm_hi[acc_addr_reg[11:1]], dm_lo[acc_addr_reg[11:1]]};
                    end
                    if (done_reg && wait_cnt_reg >= 8'(ACC_MIN_CYC - 2)) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!i_bus.rd && !i_bus.wr) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Host writes into display and font memory, one byte per position
    logic mem_wr, wr_lo, wr_hi;
    assign mem_wr = (state_reg == ST_WAIT) && !done_reg && !ref_busy && req_reg.wr;
    assign wr_lo = !req_reg.byte_wr || !req_reg.addr[0];
    assign wr_hi = !req_reg.byte_wr || req_reg.addr[0];
    always_ff @(posedge i_sys_clk) begin
        if (mem_wr && !is_cg_reg && wr_lo) begin
            dm_lo[acc_addr_reg[11:1]] <= req_reg.wdata[7:0];
        end
        if (mem_wr && !is_cg_reg && wr_hi) begin
            dm_hi[acc_addr_reg[11:1]] <= req_reg.wdata[15:8];
        end
        if (mem_wr && is_cg_reg && wr_lo) begin
            cg_lo[acc_addr_reg[11:1]] <= req_reg.wdata[7:0];
        end
        if (mem_wr && is_cg_reg && wr_hi) begin
            cg_hi[acc_addr_reg[11:1]] <= req_reg.wdata[15:8];
        end
    end
    assign o_bus_reply = (state_reg == ST_DONE);

    // ************************************************
    // Control registers and timing core registers
    // ************************************************
    logic [11:0] fetch_addr;
    logic frame_end;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            for (int i = 0; i < 16; i++) begin
                tc_reg[i] <= 8'h00;
            end
            tc_reg[TC_COLS] <= COLS_RST;
            tc_reg[TC_ROWS] <= ROWS_RST;
            tc_reg[TC_SCANS] <= SCANS_RST;
            tc_reg[TC_CUR_START] <= CUR_START_RST;
            tc_reg[TC_CUR_END] <= CUR_END_RST;
            tc_idx_reg <= 4'h0;
            win_sel_reg <= 4'h0;
            ctrl1_reg <= 8'h00;
            ctrl2_reg <= 8'h00;
            status_reg <= 8'h00;
        end else begin
            // Status read clears sticky bits, new events win
            if (take && io_hit && i_bus.rd && ofs == OFS_0) begin
                status_reg <= 8'h00;
            end
            if (frame_end) begin
                status_reg[ST_FRAME] <= 1'b1;
            end
            if (lpen_pulse) begin
                status_reg[ST_LPEN] <= 1'b1;
                tc_reg[TC_LP_HI] <= {4'h0, fetch_addr[11:8]};
                tc_reg[TC_LP_LO] <= fetch_addr[7:0];
            end
            if (take && io_hit && i_bus.wr && lo_lane) begin
                case (ofs)
                    OFS_0: tc_idx_reg <= i_bus.wdata[3:0];
                    OFS_2: begin
                        if (tc_idx_reg != TC_LP_HI && tc_idx_reg != TC_LP_LO) begin
                            tc_reg[tc_idx_reg] <= i_bus.wdata[7:0];
                        end
                    end
                    OFS_4: ctrl1_reg <= i_bus.wdata[7:0];
                    default: ctrl2_reg <= i_bus.wdata[7:0];
                endcase
            end
            if (take && io_hit && i_bus.wr && hi_lane) begin
                win_sel_reg <= i_bus.wdata[11:8];
            end
        end
    end

    // ************************************************
    // Keyboard and pen inputs
    // ************************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            key_code_reg <= 8'h00;
            key_ready_reg <= 1'b0;
            key_d_reg <= 1'b0;
            lpen_d_reg <= 1'b0;
        end else begin
            key_d_reg <= i_key_strobe;
            lpen_d_reg <= i_lpen_strobe;
            if (key_pulse) begin
                key_code_reg <= i_key_data;
                key_ready_reg <= 1'b1;
            end else if (key_rd) begin
                key_ready_reg <= 1'b0;
            end
        end
    end

    // ************************************************
    // Refresh scanner
    // ************************************************
    logic [15:0] div_cnt_reg;
    logic char_en;
    logic [7:0] col_reg, row_reg, scan_reg;
    logic [11:0] row_base_reg, start_addr, cur_addr;
    logic [12:0] row_off_reg, span, next_off;
    assign char_en = (div_cnt_reg == 16'(CHAR_DIV - 1));
    assign start_addr = {tc_reg[TC_START_HI][3:0], tc_reg[TC_START_LO]};
    assign cur_addr = {tc_reg[TC_CUR_HI][3:0], tc_reg[TC_CUR_LO]};
    assign span = {5'h00, tc_reg[TC_COLS]} + 13'h0001;
    assign next_off = row_off_reg + span;
    assign fetch_addr = row_base_reg + col_reg;
    // Frame stops at the last row or before passing 4000 characters
    assign frame_end = char_en && col_reg == tc_reg[TC_COLS]
        && scan_reg == tc_reg[TC_SCANS]
        && (row_reg == tc_reg[TC_ROWS] || next_off + span > MAX_SCREEN);
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            div_cnt_reg <= 16'h0000;
            col_reg <= 8'h00;
            row_reg <= 8'h00;
            scan_reg <= 8'h00;
            row_base_reg <= 12'h000;
            row_off_reg <= 13'h0000;
            o_frame_start <= 1'b0;
        end else begin
            div_cnt_reg <= char_en ? 16'h0000 : div_cnt_reg + 16'h0001;
            o_frame_start <= frame_end;
            if (frame_end) begin
                col_reg <= 8'h00;
                scan_reg <= 8'h00;
                row_reg <= 8'h00;
                row_base_reg <= start_addr;
                row_off_reg <= 13'h0000;
            end else if (char_en && col_reg == tc_reg[TC_COLS]) begin
                col_reg <= 8'h00;
                if (scan_reg == tc_reg[TC_SCANS]) begin
                    scan_reg <= 8'h00;
                    row_reg <= row_reg + 8'h01;
                    row_base_reg <= row_base_reg + span[11:0];
                    row_off_reg <= next_off;
                end else begin
                    scan_reg <= scan_reg + 8'h01;
                end
            end else if (char_en) begin
                col_reg <= col_reg + 8'h01;
            end
        end
    end

    // ************************************************
    // Cursor blink
    // ************************************************
    logic [25:0] blink_cnt_reg;
    logic blink_ph_reg;
    logic [25:0] blink_lim;
    assign blink_lim = ctrl2_reg[C2_BLINK_FAST] ? 26'(BLINK_FAST - 1) : 26'(BLINK_SLOW - 1);
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            blink_cnt_reg <= 26'h0000000;
            blink_ph_reg <= 1'b0;
        end else if (blink_cnt_reg >= blink_lim) begin
            blink_cnt_reg <= 26'h0000000;
            blink_ph_reg <= !blink_ph_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 26'h0000001;
        end
    end

    // ************************************************
    // Fetch and glyph pipeline
    // ************************************************
    logic f1_reg;
    logic [7:0] code_reg, scan_d_reg;
    logic [11:0] f_addr_reg;
    logic [7:0] gi;
    logic [4:0] flags;
    logic [7:0] glyph;
    logic cur_hit;
    assign ref_busy = char_en || f1_reg;
    // Glyph index per strap set
    assign gi = !i_small_set ? {1'b0, code_reg[6:0]}
        : i_gen_split ? {code_reg[6], 1'b0, code_reg[5:0]}
        : {2'b00, code_reg[5:0]};
    assign flags = (code_reg[7] ? attr_flags(i_attr_a) : 5'h00)
        | ((i_small_set && !i_gen_split && code_reg[6]) ? attr_flags(i_attr_b) : 5'h00);
    assign glyph = scan_d_reg[0] ? cg_hi[{gi, scan_d_reg[3:1]}] : cg_lo[{gi, scan_d_reg[3:1]}];
    assign cur_hit = (f_addr_reg == cur_addr)
        && scan_d_reg >= tc_reg[TC_CUR_START] && scan_d_reg <= tc_reg[TC_CUR_END]
        && (!ctrl2_reg[C2_CUR_BLINK] || blink_ph_reg);
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            f1_reg <= 1'b0;
            code_reg <= 8'h00;
            scan_d_reg <= 8'h00;
            f_addr_reg <= 12'h000;
            o_vid <= '0;
        end else begin
            f1_reg <= char_en;
            if (char_en) begin
                code_reg <= fetch_addr[0] ? dm_hi[fetch_addr[11:1]] : dm_lo[fetch_addr[11:1]];
                scan_d_reg <= scan_reg;
                f_addr_reg <= fetch_addr;
            end
            o_vid.valid <= f1_reg;
            if (f1_reg) begin
                o_vid.dots <= !ctrl2_reg[C2_VID_EN] ? 8'h00
                    : glyph ^ {8{flags[0]}} ^ {8{cur_hit}};
                o_vid.underline <= flags[1];
                o_vid.tall <= flags[2];
                o_vid.blink <= flags[3];
                o_vid.fg_off <= flags[4];
                o_vid.cursor <= cur_hit;
            end
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    logic mem_acc;
    assign mem_acc = (state_reg != ST_IDLE) && (wait_cnt_reg != 8'h00 || done_reg);
    a_reply_min_time: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(o_bus_reply) && $past(state_reg) == ST_WAIT |-> wait_cnt_reg >= 8'(ACC_MIN_CYC - 1))
        else $error("memory reply too early");
    a_reply_max_time: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        state_reg == ST_WAIT |-> wait_cnt_reg < 8'(ACC_MAX_CYC - 1))
        else $error("memory reply too late");
    a_grant_before: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        state_reg == ST_WAIT ##1 state_reg == ST_DONE |-> $past(done_reg))
        else $error("reply without grant");
    a_no_refresh_clash: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(done_reg) |-> !$past(ref_busy))
        else $error("host access during refresh");
    a_window_block: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && mem_hit && !full_hit |=> acc_addr_reg == {$past(win_sel_reg), $past(i_bus.addr[7:0])})
        else $error("window block wrong");
    a_window_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && !io_hit && !full_hit |-> ctrl1_reg[C1_WIN_EN])
        else $error("window answered while off");
    a_font_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        take && !io_hit && !full_hit && !ctrl1_reg[C1_CG_EN] |=> !is_cg_reg)
        else $error("font reached while off");
    a_key_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        key_pulse |=> key_ready_reg && key_code_reg == $past(i_key_data))
        else $error("key not latched");
    a_key_flag_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        key_rd && !key_pulse |=> !key_ready_reg)
        else $error("key flag not cleared");
    a_pen_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        lpen_pulse |=> tc_reg[TC_LP_LO] == $past(fetch_addr[7:0]) && status_reg[ST_LPEN])
        else $error("pen not captured");
    a_frame_restart: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        frame_end |=> row_base_reg == $past(start_addr) && col_reg == 8'h00)
        else $error("frame not restarted");
    c_mem_reply: cover property (@(posedge i_sys_clk) disable iff (i_rst) mem_acc && $rose(o_bus_reply));
    c_key_read: cover property (@(posedge i_sys_clk) disable iff (i_rst) key_ready_reg ##1 key_rd);
    c_pen_hit: cover property (@(posedge i_sys_clk) disable iff (i_rst) lpen_pulse);
    c_cursor_shown: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_vid.cursor);
endmodule

// File: adhp_pkg.sv
// Constants, types and register map of the display host port.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package adhp_pkg;
    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CLK_HZ = 125000000;
    localparam int ACC_MIN_NS = 315;
    localparam int ACC_MAX_NS = 1052;
    localparam int ACC_MIN_CYC = (ACC_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACC_MAX_CYC = (ACC_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int BLINK_SLOW_HZ = 2;
    localparam int BLINK_FAST_HZ = 4;
    localparam int BLINK_SLOW_CYC = CLK_HZ / (2 * BLINK_SLOW_HZ);
    localparam int BLINK_FAST_CYC = CLK_HZ / (2 * BLINK_FAST_HZ);
    // ************************************************
    // Address map
    // ************************************************
    localparam logic [4:0] IO_PAGE = 5'h1F;
    localparam logic [1:0] OFS_0 = 2'h0;
    localparam logic [1:0] OFS_2 = 2'h1;
    localparam logic [1:0] OFS_4 = 2'h2;
    localparam logic [1:0] OFS_6 = 2'h3;
    localparam int C1_WIN_EN = 0;
    localparam int C1_CG_EN = 1;
    localparam int C1_FULL_EN = 2;
    localparam int C2_BLINK_FAST = 0;
    localparam int C2_CUR_BLINK = 1;
    localparam int C2_VID_EN = 2;
    localparam int ST_FRAME = 5;
    localparam int ST_LPEN = 6;
    localparam int KF_READY = 7;
    // Screen timing core register indexes
    localparam logic [3:0] TC_COLS = 4'h0;
    localparam logic [3:0] TC_ROWS = 4'h1;
    localparam logic [3:0] TC_SCANS = 4'h2;
    localparam logic [3:0] TC_CUR_START = 4'h3;
    localparam logic [3:0] TC_CUR_END = 4'h4;
    localparam logic [3:0] TC_START_HI = 4'h5;
    localparam logic [3:0] TC_START_LO = 4'h6;
    localparam logic [3:0] TC_CUR_HI = 4'h7;
    localparam logic [3:0] TC_CUR_LO = 4'h8;
    localparam logic [3:0] TC_LP_HI = 4'h9;
    localparam logic [3:0] TC_LP_LO = 4'hA;
    localparam logic [7:0] COLS_RST = 8'h4F;
    localparam logic [7:0] ROWS_RST = 8'h17;
    localparam logic [7:0] SCANS_RST = 8'h09;
    localparam logic [7:0] CUR_START_RST = 8'h08;
    localparam logic [7:0] CUR_END_RST = 8'h09;
    localparam logic [12:0] MAX_SCREEN = 13'h0FA0;
    // ************************************************
    // Types
    // ************************************************
    typedef enum logic [2:0] {
        ATTR_INVERSE = 3'b000,
        ATTR_UNDERLINE = 3'b001,
        ATTR_TALL = 3'b010,
        ATTR_BLINK = 3'b011,
        ATTR_FG_OFF = 3'b100
    } adhp_attr_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } adhp_state_t;
    typedef struct packed {
        logic [17:0] addr;
        logic [15:0] wdata;
        logic rd;
        logic wr;
        logic byte_wr;
    } adhp_req_t;
    typedef struct packed {
        logic [7:0] dots;
        logic underline;
        logic tall;
        logic blink;
        logic fg_off;
        logic cursor;
        logic valid;
    } adhp_vid_t;
endpackage

// File: adhp_host_model.sv
// Host processor model driving the display port request lines.
// Assumes reply and read data are sampled on the rising clock edge.
`timescale 1ns/1ps
module adhp_host_model
    import adhp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reply,
    input wire logic [15:0] i_rdata,
    output adhp_req_t o_bus
);
    initial o_bus = '0;
    // One transfer, strobe held until reply, released lines scrambled
    task automatic xfer(input logic [17:0] a, input logic [15:0] d, input logic w,
        input logic b, output logic [15:0] q, output int n);
        n = 0;
        @(posedge i_sys_clk);
        #1 o_bus = '{addr: a, wdata: d, rd: !w, wr: w, byte_wr: b};
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (i_reply !== 1'b1 && n < 200); // Bounded wait
        q = i_rdata;
        #1 o_bus = '{addr: ~a, wdata: ~d, default: 1'b0};
        repeat (2) @(posedge i_sys_clk);
    endtask
endmodule

// File: alpha_display_host_port_test.sv
// Self-checking bench for the display host port.
// Assumes the host model above as the only bus master.
`timescale 1ns/1ps
module alpha_display_host_port_test
    import adhp_pkg::*;
;
    localparam logic [17:0] A = 18'h3FE40;
    logic i_sys_clk = 0, i_rst = 1, i_key_strobe = 0, rep;
    logic small_set = 0, gen_split = 0, lpen_en = 0, lpen_stb = 0, fs;
    adhp_vid_t vid;
    logic [7:0] i_key_data = 8'h00;
    logic [15:0] rd, q;
    adhp_req_t bus;
    int n, mismatches = 0, samples_checked = 0;
    initial forever #4 i_sys_clk = ~i_sys_clk;
    adhp_host_model host_u (.i_sys_clk(i_sys_clk), .i_reply(rep), .i_rdata(rd), .o_bus(bus));
    adhp_host_port #(.BLINK_SLOW(20), .BLINK_FAST(10)) dut_u (.i_sys_clk(i_sys_clk),
        .i_rst(i_rst), .i_bus(bus), .o_bus_rdata(rd), .o_bus_reply(rep),
        .i_csr_base(10'h3C8), .i_win_base(10'h010), .i_full_base(6'h20),
        .i_attr_a(ATTR_INVERSE), .i_attr_b(ATTR_BLINK), .i_small_set(small_set),
        .i_gen_split(gen_split), .i_key_data(i_key_data), .i_key_strobe(i_key_strobe),
        .i_lpen_enable(lpen_en), .i_lpen_strobe(lpen_stb), .o_vid(vid), .o_frame_start(fs));
    // Compare one value
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Verdict and end of run
    task automatic results;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Timing register reset value, write and read back
    task automatic t_regs;
        host_u.xfer(A, 16'h0000, 1, 1, q, n);
        host_u.xfer(A + 2, 16'h0000, 0, 1, q, n);
        chk(q, 16'h004F);
        host_u.xfer(A + 2, 16'h0028, 1, 1, q, n);
        host_u.xfer(A + 2, 16'h0000, 0, 1, q, n);
        chk(q, 16'h0028);
    endtask
    // Window block select, byte lanes, latency, full map, disable
    task automatic t_mem;
        host_u.xfer(A + 4, 16'h0005, 1, 1, q, n);
        host_u.xfer(A + 1, 16'h0500, 1, 1, q, n);
        host_u.xfer(18'h01002, 16'h5AC3, 1, 0, q, n);
        chk(16'(n), 16'd41);
        host_u.xfer(18'h01003, 16'h7E00, 1, 1, q, n);
        host_u.xfer(18'h01002, 16'h0000, 0, 0, q, n);
        chk(q, 16'h7EC3);
        host_u.xfer(18'h20502, 16'h0000, 0, 0, q, n);
        chk(q, 16'h7EC3);
        host_u.xfer(A + 4, 16'h0007, 1, 1, q, n);
        host_u.xfer(18'h01002, 16'h1234, 1, 0, q, n);
        host_u.xfer(18'h20502, 16'h0000, 0, 0, q, n);
        chk(q, 16'h7EC3);
        host_u.xfer(18'h01002, 16'h0000, 0, 0, q, n);
        chk(q, 16'h1234);
        host_u.xfer(A + 4, 16'h0000, 1, 1, q, n);
        host_u.xfer(18'h01002, 16'h0000, 0, 0, q, n);
        chk(16'(n), 16'd200);
    endtask
    // Key strobe sets flag, code read returns key and clears flag
    task automatic t_key;
        @(posedge i_sys_clk);
        #1 i_key_data = 8'h41;
        i_key_strobe = 1;
        @(posedge i_sys_clk);
        #1 i_key_strobe = 0;
        host_u.xfer(A + 6, 16'h0000, 0, 1, q, n);
        chk(q, 16'h0080);
        host_u.xfer(A + 4, 16'h0000, 0, 1, q, n);
        chk(q, 16'h0041);
        host_u.xfer(A + 6, 16'h0000, 0, 1, q, n);
        chk(q, 16'h0000);
    endtask
    // Mid-run reset, one-row screen of 8 slots, frame period and slot pulses
    task automatic t_vid;
        int v;
        @(posedge i_sys_clk);
        #1 i_rst = 1;
        repeat (2) @(posedge i_sys_clk);
        #1 i_rst = 0;
        host_u.xfer(A, 16'h0001, 1, 1, q, n);
        host_u.xfer(A + 2, 16'h0000, 1, 1, q, n);
        host_u.xfer(A, 16'h0002, 1, 1, q, n);
        host_u.xfer(A + 2, 16'h0000, 1, 1, q, n);
        host_u.xfer(A, 16'h0000, 1, 1, q, n);
        host_u.xfer(A + 2, 16'h0007, 1, 1, q, n);
        host_u.xfer(A, 16'h0005, 1, 1, q, n);
        host_u.xfer(A + 2, 16'h0003, 1, 1, q, n);
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (fs !== 1'b1 && n < 200);
        n = 0;
        v = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
            v += vid.valid;
        end while (fs !== 1'b1 && n < 200);
        chk(16'(n), 16'd64);
        chk(16'(v), 16'd8);
        chk({8'h00, vid.dots}, 16'h0000);
    endtask
    // Pen strobe flags status, captures refresh address, ignores writes
    task automatic t_pen;
        @(posedge i_sys_clk);
        #1 lpen_en = 1;
        lpen_stb = 1;
        @(posedge i_sys_clk);
        #1 lpen_stb = 0;
        host_u.xfer(A, 16'h0000, 0, 1, q, n);
        chk(q, 16'h0060);
        host_u.xfer(A, 16'h0009, 1, 1, q, n);
        host_u.xfer(A + 2, 16'h00FF, 1, 1, q, n);
        host_u.xfer(A + 2, 16'h0000, 0, 1, q, n);
        chk(q, 16'h0003);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge i_sys_clk);
        #1 i_rst = 0;
        t_regs();
        t_mem();
        t_key();
        t_vid();
        t_pen();
        results();
    end
    // Watchdog
    initial begin
        #50000;
        mismatches++;
        results();
    end
endmodule
